// ==== src/calendar_regs.sv ====
// The strobed register port is this design's own decision.
`timescale 1ns/100ps
module calendar_regs #(
	parameter bit TUNER_PRESENT = 1'b1,
	parameter bit TUNER_POWER_WRITABLE = 1'b1,
	parameter logic [4:0] TUNER_FIXED_POWER = 5'h00,
	parameter logic [1:0] ALARM_COUNT = 2'h1,
	parameter bit PERIODIC_COUNT_CODE = 1'b0,
	parameter bit INTERVAL0_TAP_WRITABLE = 1'b1,
	parameter bit INTERVAL1_TAP_WRITABLE = 1'b0,
	parameter logic [4:0] INTERVAL0_FIXED_TAP = 5'h00,
	parameter logic [4:0] INTERVAL1_FIXED_TAP = 5'h00
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rd_data,
	input wire logic busy,
	input wire logic sec_tick,
	output logic [31:0] calendar_value,
	output logic [4:0] tuner_power,
	output logic tuner_add,
	output logic [7:0] tuner_adjust,
	output logic [4:0] interval0_tap,
	output logic [4:0] interval1_tap
);

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction : reg_hit

	logic [31:0] cal_reg;
	logic [31:0] cal_next;
	logic [31:0] rd_data_reg;
	logic add_reg;
	logic [7:0] adjust_reg;
	logic [31:0] opts_word;
	logic [4:0] taps [2];
	logic cal_wr;
	logic tuner_wr;
	// Tuner absent behaves as if the register were not there
	localparam bit TUNER_ON = TUNER_PRESENT;

	assign cal_wr = wr_en && reg_hit(addr, cal_pkg::OFF_CAL) && !busy;
	assign tuner_wr = wr_en && reg_hit(addr, cal_pkg::OFF_TUNER) && !busy && TUNER_ON;

	// ------------------------------------------------------------
	// Calendar value
	// ------------------------------------------------------------
	logic [31:0] cal_now_w;
	assign cal_now_w = cal_reg;
	calendar_step u_step (
		.cal_now(cal_now_w),
		.cal_next(cal_next)
	);

	// Software write wins over a tick in the same cycle: the written
	// time is what the user asked for, the lost second is negligible
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cal_reg <= cal_pkg::CAL_RESET;
		end else if (cal_wr) begin
			cal_reg <= wr_data;
		end else if (sec_tick) begin
			cal_reg <= cal_next;
		end
	end

	assign calendar_value = cal_reg;

	// ------------------------------------------------------------
	// Tuner register
	// ------------------------------------------------------------
	// power field follows the writable option
	option_field #(
		.W(cal_pkg::POWER_W),
		.WRITABLE(TUNER_POWER_WRITABLE),
		.FIXED(TUNER_FIXED_POWER)
	) u_power (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.wr_hit(tuner_wr),
		.wr_val(wr_data[cal_pkg::POWER_LSB +: cal_pkg::POWER_W]),
		.val(tuner_power)
	);

	// Add flag and adjust amount are writable when the tuner is present and busy is low
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			add_reg <= 1'b0;
			adjust_reg <= 8'h00;
		end else if (tuner_wr) begin
			add_reg <= wr_data[cal_pkg::ADD_BIT];
			adjust_reg <= wr_data[cal_pkg::ADJ_LSB +: cal_pkg::ADJ_W];
		end
	end

	assign tuner_add = add_reg;
	assign tuner_adjust = adjust_reg;

	// ------------------------------------------------------------
	// Interval tap selects
	// ------------------------------------------------------------
	// each tap follows its writable option
	for (genvar i = 0; i < 2; i++) begin : g_tap
		localparam logic [7:0] TAP_OFF = 8'(cal_pkg::OFF_TAP0 + 8'(i) * cal_pkg::OFF_TAP_STEP);
		option_field #(
			.W(cal_pkg::TAP_W),
			.WRITABLE(i == 0 ? INTERVAL0_TAP_WRITABLE : INTERVAL1_TAP_WRITABLE),
			.FIXED(i == 0 ? INTERVAL0_FIXED_TAP : INTERVAL1_FIXED_TAP)
		) u_tap (
			.sys_clk(sys_clk),
			.nrst(nrst),
			.wr_hit(wr_en && reg_hit(addr, TAP_OFF) && !busy),
			.wr_val(wr_data[cal_pkg::TAP_LSB +: cal_pkg::TAP_W]),
			.val(taps[i])
		);
	end

	assign interval0_tap = taps[0];
	assign interval1_tap = taps[1];

	// ------------------------------------------------------------
	// Build options word
	// ------------------------------------------------------------
	// build configuration image
	always_comb begin
		opts_word = 32'h0000_0000;
		opts_word[cal_pkg::OPT_TUNER_BIT] = TUNER_PRESENT;
		opts_word[cal_pkg::OPT_POWER_WA_BIT] = TUNER_POWER_WRITABLE;
		opts_word[cal_pkg::OPT_POWER_LSB +: cal_pkg::POWER_W] = TUNER_FIXED_POWER;
		opts_word[cal_pkg::OPT_ALARM_LSB +: cal_pkg::OPT_ALARM_W] = ALARM_COUNT;
		opts_word[cal_pkg::OPT_PERIODIC_BIT] = PERIODIC_COUNT_CODE;
		opts_word[cal_pkg::OPT_TAP0_WA_BIT] = INTERVAL0_TAP_WRITABLE;
		opts_word[cal_pkg::OPT_TAP1_WA_BIT] = INTERVAL1_TAP_WRITABLE;
		opts_word[cal_pkg::OPT_TAP0_LSB +: cal_pkg::TAP_W] = INTERVAL0_FIXED_TAP;
		opts_word[cal_pkg::OPT_TAP1_LSB +: cal_pkg::TAP_W] = INTERVAL1_FIXED_TAP;
	end

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	// Data stand only in the cycle after the strobe, zero otherwise
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rd_data_reg <= 32'h0000_0000;
		end else if (rd_en) begin
			rd_data_reg <= 32'h0000_0000;
			if (reg_hit(addr, cal_pkg::OFF_CAL)) begin
				rd_data_reg <= busy ? 32'h0000_0000 : cal_reg;
			end else if (reg_hit(addr, cal_pkg::OFF_OPTS)) begin
				rd_data_reg <= opts_word;
			end else if (reg_hit(addr, cal_pkg::OFF_STATUS)) begin
				rd_data_reg[cal_pkg::BUSY_BIT] <= busy;
			end else if (reg_hit(addr, cal_pkg::OFF_TUNER) && !busy && TUNER_ON) begin
				rd_data_reg[cal_pkg::POWER_LSB +: cal_pkg::POWER_W] <= tuner_power;
				rd_data_reg[cal_pkg::ADD_BIT] <= add_reg;
				rd_data_reg[cal_pkg::ADJ_LSB +: cal_pkg::ADJ_W] <= adjust_reg;
			end else if (reg_hit(addr, cal_pkg::OFF_TAP0)) begin
				rd_data_reg[cal_pkg::TAP_LSB +: cal_pkg::TAP_W] <= taps[0];
			end else if (reg_hit(addr, 8'(cal_pkg::OFF_TAP0 + cal_pkg::OFF_TAP_STEP))) begin
				rd_data_reg[cal_pkg::TAP_LSB +: cal_pkg::TAP_W] <= taps[1];
			end
		end else begin
			rd_data_reg <= 32'h0000_0000;
		end
	end

	assign rd_data = rd_data_reg;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	logic [5:0] f_year;
	logic [3:0] f_month;
	logic [4:0] f_day;
	logic [4:0] f_hour;
	logic [5:0] f_min;
	logic [5:0] f_sec;
	logic end_of_day;
	logic cal_tick;
	assign f_year = cal_reg[cal_pkg::YEAR_LSB +: cal_pkg::YEAR_W];
	assign f_month = cal_reg[cal_pkg::MONTH_LSB +: cal_pkg::MONTH_W];
	assign f_day = cal_reg[cal_pkg::DAY_LSB +: cal_pkg::DAY_W];
	assign f_hour = cal_reg[cal_pkg::HOUR_LSB +: cal_pkg::HOUR_W];
	assign f_min = cal_reg[cal_pkg::MIN_LSB +: cal_pkg::MIN_W];
	assign f_sec = cal_reg[cal_pkg::SEC_LSB +: cal_pkg::SEC_W];
	assign end_of_day = f_hour == cal_pkg::HOUR_LAST && f_min == cal_pkg::MIN_LAST
		&& f_sec == cal_pkg::SEC_LAST;
	assign cal_tick = sec_tick && !cal_wr;

	property p_busy_drop;
		busy && wr_en && reg_hit(addr, cal_pkg::OFF_CAL) && !sec_tick |=> $stable(cal_reg);
	endproperty
	a_busy_drop: assert property (p_busy_drop) else $error("calendar took a write while busy");

	property p_busy_read;
		rd_en && reg_hit(addr, cal_pkg::OFF_CAL) && busy |=> rd_data == 32'h0000_0000;
	endproperty
	a_busy_read: assert property (p_busy_read) else $error("calendar read not zero while busy");

	property p_cal_read;
		rd_en && reg_hit(addr, cal_pkg::OFF_CAL) && !busy |=> rd_data == $past(cal_reg)
			##1 rd_data == 32'h0000_0000 || $past(rd_en);
	endproperty
	a_cal_read: assert property (p_cal_read) else $error("calendar read data wrong");

	property p_leap_feb;
		cal_tick && f_month == cal_pkg::MONTH_FEB && f_day == 5'h1C && end_of_day
			|=> f_day == ((f_year[1:0] == 2'h0) ? 5'h1D : cal_pkg::DAY_FIRST);
	endproperty
	a_leap_feb: assert property (p_leap_feb) else $error("leap day handled wrongly");

	property p_year_end;
		cal_tick && f_month == cal_pkg::MONTH_LAST && f_day == 5'h1F && end_of_day
			|=> f_month == cal_pkg::MONTH_FIRST && f_year == 6'($past(f_year) + 6'h01);
	endproperty
	a_year_end: assert property (p_year_end) else $error("December did not roll over");

	property p_day_first;
		cal_tick && end_of_day |=> (f_month != $past(f_month)) |-> f_day == cal_pkg::DAY_FIRST;
	endproperty
	a_day_first: assert property (p_day_first) else $error("new month not on day one");

	property p_hour_wrap;
		cal_tick && end_of_day |=> f_hour == 5'h00 && f_min == 6'h00 && f_sec == 6'h00;
	endproperty
	a_hour_wrap: assert property (p_hour_wrap) else $error("hour did not wrap after 23");

	property p_min_wrap;
		cal_tick && f_sec == cal_pkg::SEC_LAST && f_min < cal_pkg::MIN_LAST
			|=> f_min == 6'($past(f_min) + 6'h01) && f_sec == 6'h00;
	endproperty
	a_min_wrap: assert property (p_min_wrap) else $error("minute carry wrong");

	property p_sec_step;
		cal_tick && f_sec < cal_pkg::SEC_LAST |=> f_sec == 6'($past(f_sec) + 6'h01)
			&& f_min == $past(f_min);
	endproperty
	a_sec_step: assert property (p_sec_step) else $error("second step wrong");

	property p_opts_read;
		rd_en && reg_hit(addr, cal_pkg::OFF_OPTS) |=> rd_data == opts_word
			&& rd_data[cal_pkg::OPT_TUNER_BIT] == TUNER_PRESENT;
	endproperty
	a_opts_read: assert property (p_opts_read) else $error("build options read wrong");

	property p_counts;
		rd_en && reg_hit(addr, cal_pkg::OFF_OPTS)
			|=> rd_data[cal_pkg::OPT_ALARM_LSB +: cal_pkg::OPT_ALARM_W] != 2'h3;
	endproperty
	a_counts: assert property (p_counts) else $error("alarm count out of range");

	property p_power;
		tuner_wr |=> tuner_power == (TUNER_POWER_WRITABLE
			? $past(wr_data[cal_pkg::POWER_LSB +: cal_pkg::POWER_W]) : TUNER_FIXED_POWER);
	endproperty
	a_power: assert property (p_power) else $error("tuner power write handling wrong");

	property p_tap0;
		wr_en && reg_hit(addr, cal_pkg::OFF_TAP0) && !busy |=> interval0_tap
			== (INTERVAL0_TAP_WRITABLE ? $past(wr_data[cal_pkg::TAP_LSB +: cal_pkg::TAP_W])
			: INTERVAL0_FIXED_TAP);
	endproperty
	a_tap0: assert property (p_tap0) else $error("interval tap write handling wrong");

	property p_tap1;
		wr_en && reg_hit(addr, 8'(cal_pkg::OFF_TAP0 + cal_pkg::OFF_TAP_STEP)) && !busy
			|=> interval1_tap == (INTERVAL1_TAP_WRITABLE
			? $past(wr_data[cal_pkg::TAP_LSB +: cal_pkg::TAP_W]) : INTERVAL1_FIXED_TAP);
	endproperty
	a_tap1: assert property (p_tap1) else $error("interval1 tap write wrong");

	// ------------------------------------------------------------
	// Range keeping across a tick
	// ------------------------------------------------------------
	// Only fields that start legal are held to it: a value written out
	// of range is software's doing and simply carries at the next tick
	property p_cal_write;
		cal_wr |=> cal_reg == $past(wr_data);
	endproperty
	a_cal_write: assert property (p_cal_write) else $error("calendar write not taken");

	property p_month_range;
		cal_tick && f_month >= cal_pkg::MONTH_FIRST && f_month <= cal_pkg::MONTH_LAST
			|=> f_month >= cal_pkg::MONTH_FIRST && f_month <= cal_pkg::MONTH_LAST;
	endproperty
	a_month_range: assert property (p_month_range) else $error("month left 1 to 12");

	property p_day_range;
		cal_tick && f_day >= cal_pkg::DAY_FIRST |=> f_day >= cal_pkg::DAY_FIRST;
	endproperty
	a_day_range: assert property (p_day_range) else $error("day fell to zero");

	property p_hour_range;
		cal_tick && f_hour <= cal_pkg::HOUR_LAST |=> f_hour <= cal_pkg::HOUR_LAST;
	endproperty
	a_hour_range: assert property (p_hour_range) else $error("hour left 0 to 23");

	property p_min_range;
		cal_tick && f_min <= cal_pkg::MIN_LAST |=> f_min <= cal_pkg::MIN_LAST;
	endproperty
	a_min_range: assert property (p_min_range) else $error("minute left 0 to 59");

	property p_sec_range;
		cal_tick && f_sec <= cal_pkg::SEC_LAST |=> f_sec <= cal_pkg::SEC_LAST;
	endproperty
	a_sec_range: assert property (p_sec_range) else $error("second left 0 to 59");

	c_tap_write: cover property (wr_en && !busy && reg_hit(addr, cal_pkg::OFF_TAP0));
	c_cal_write: cover property (cal_wr ##1 rd_en && reg_hit(addr, cal_pkg::OFF_CAL));
	c_busy_read: cover property (rd_en && busy && reg_hit(addr, cal_pkg::OFF_CAL));
	c_year_roll: cover property (cal_tick && f_month == cal_pkg::MONTH_LAST && end_of_day);
	c_leap_day: cover property (cal_tick && f_month == cal_pkg::MONTH_FEB && f_day == 5'h1C
		&& end_of_day && f_year[1:0] == 2'h0);

endmodule : calendar_regs

// ==== src/cal_pkg.sv ====
package cal_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_STATUS = 8'h2C;
	localparam logic [7:0] OFF_TAP0 = 8'h38;
	localparam logic [7:0] OFF_TAP_STEP = 8'h04;
	localparam logic [7:0] OFF_TUNER = 8'h44;
	localparam logic [7:0] OFF_CAL = 8'h54;
	localparam logic [7:0] OFF_OPTS = 8'hF0;

	// ------------------------------------------------------------
	// Calendar value fields
	// ------------------------------------------------------------
	localparam int YEAR_LSB = 26;
	localparam int YEAR_W = 6;
	localparam int MONTH_LSB = 22;
	localparam int MONTH_W = 4;
	localparam int DAY_LSB = 17;
	localparam int DAY_W = 5;
	localparam int HOUR_LSB = 12;
	localparam int HOUR_W = 5;
	localparam int MIN_LSB = 6;
	localparam int MIN_W = 6;
	localparam int SEC_LSB = 0;
	localparam int SEC_W = 6;
	localparam logic [3:0] MONTH_FIRST = 4'h1;
	localparam logic [3:0] MONTH_FEB = 4'h2;
	localparam logic [3:0] MONTH_LAST = 4'hC;
	localparam logic [4:0] DAY_FIRST = 5'h01;
	localparam logic [4:0] HOUR_LAST = 5'h17;
	localparam logic [5:0] MIN_LAST = 6'h3B;
	localparam logic [5:0] SEC_LAST = 6'h3B;
	localparam logic [31:0] CAL_RESET = 32'h0000_0000;

	// ------------------------------------------------------------
	// Tuner, tap and status fields
	// ------------------------------------------------------------
	localparam int POWER_LSB = 0;
	localparam int POWER_W = 5;
	localparam int ADD_BIT = 5;
	localparam int ADJ_LSB = 8;
	localparam int ADJ_W = 8;
	localparam int TAP_LSB = 0;
	localparam int TAP_W = 5;
	localparam int BUSY_BIT = 0;

	// ------------------------------------------------------------
	// Build option fields
	// ------------------------------------------------------------
	localparam int OPT_TUNER_BIT = 0;
	localparam int OPT_POWER_WA_BIT = 1;
	localparam int OPT_POWER_LSB = 2;
	localparam int OPT_ALARM_LSB = 8;
	localparam int OPT_ALARM_W = 2;
	localparam int OPT_PERIODIC_BIT = 12;
	localparam int OPT_TAP0_WA_BIT = 14;
	localparam int OPT_TAP1_WA_BIT = 15;
	localparam int OPT_TAP0_LSB = 16;
	localparam int OPT_TAP1_LSB = 24;

endpackage : cal_pkg

// ==== src/calendar_step.sv ====
`timescale 1ns/100ps
module calendar_step (
	input wire logic [31:0] cal_now,
	output logic [31:0] cal_next
);

	// ------------------------------------------------------------
	// Month length
	// ------------------------------------------------------------
	// leap year test
	function automatic logic [4:0] month_days(input logic [3:0] month, input logic [5:0] year);
		logic [4:0] days;
		days = 5'h1F;
		case (month)
			4'h2: days = (year[1:0] == 2'h0) ? 5'h1D : 5'h1C;
			4'h4, 4'h6, 4'h9, 4'hB: days = 5'h1E;
			default: days = 5'h1F;
		endcase
		return days;
	endfunction : month_days

	// ------------------------------------------------------------
	// Carry chain from seconds up to year
	// ------------------------------------------------------------
	always_comb begin
		logic [5:0] year;
		logic [3:0] month;
		logic [4:0] day;
		logic [4:0] hour;
		logic [5:0] mins;
		logic [5:0] secs;
		year = cal_now[cal_pkg::YEAR_LSB +: cal_pkg::YEAR_W];
		month = cal_now[cal_pkg::MONTH_LSB +: cal_pkg::MONTH_W];
		day = cal_now[cal_pkg::DAY_LSB +: cal_pkg::DAY_W];
		hour = cal_now[cal_pkg::HOUR_LSB +: cal_pkg::HOUR_W];
		mins = cal_now[cal_pkg::MIN_LSB +: cal_pkg::MIN_W];
		secs = cal_now[cal_pkg::SEC_LSB +: cal_pkg::SEC_W];
		if (secs >= cal_pkg::SEC_LAST) begin
			secs = 6'h00;
			if (mins >= cal_pkg::MIN_LAST) begin
				mins = 6'h00;
				if (hour >= cal_pkg::HOUR_LAST) begin
					hour = 5'h00;
					if (day >= month_days(month, year)) begin
						day = cal_pkg::DAY_FIRST;
						if (month >= cal_pkg::MONTH_LAST || month == 4'h0) begin
							month = cal_pkg::MONTH_FIRST;
							year = 6'(year + 6'h01);
						end else begin
							month = 4'(month + 4'h1);
						end
					end else begin
						day = 5'(day + 5'h01);
					end
				end else begin
					hour = 5'(hour + 5'h01);
				end
			end else begin
				mins = 6'(mins + 6'h01);
			end
		end else begin
			secs = 6'(secs + 6'h01);
		end
		cal_next = {year, month, day, hour, mins, secs};
	end

endmodule : calendar_step

// ==== src/option_field.sv ====
`timescale 1ns/100ps
module option_field #(
	parameter int W = 5,
	parameter bit WRITABLE = 1'b1,
	parameter logic [W-1:0] FIXED = '0
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic wr_hit,
	input wire logic [W-1:0] wr_val,
	output logic [W-1:0] val
);

	// ------------------------------------------------------------
	// Field that is either software-set or frozen at build time
	// ------------------------------------------------------------
	logic [W-1:0] val_reg;

	// Frozen fields never load, so a tie to FIXED is all that remains
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			val_reg <= FIXED;
		end else if (WRITABLE && wr_hit) begin
			val_reg <= wr_val;
		end
	end

	assign val = val_reg;

endmodule : option_field

// ==== tb/calendar_regs_tb_top.sv ====
`timescale 1ns/100ps
module calendar_regs_tb_top;

	// ------------------------------------------------------------
	// Clock, reset and bus signals
	// ------------------------------------------------------------
	logic sys_clk;
	logic nrst;
	logic [7:0] addr;
	logic [31:0] wr_data;
	logic wr_en;
	logic rd_en;
	logic busy;
	logic sec_tick;
	logic [31:0] rd_data;
	logic [31:0] calendar_value;
	logic [4:0] tuner_power;
	logic tuner_add;
	logic [7:0] tuner_adjust;
	logic [4:0] interval0_tap;
	logic [4:0] interval1_tap;
	logic [31:0] rd_data_alt;
	logic [4:0] tuner_power_alt;
	logic [4:0] interval0_tap_alt;
	logic [4:0] interval1_tap_alt;
	int errors;
	int total_checks;

	// ------------------------------------------------------------
	// Devices: default build and a build with the tuner and tap options flipped
	// ------------------------------------------------------------
	calendar_regs i_dut (
		.sys_clk(sys_clk), .nrst(nrst), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .busy(busy),
		.sec_tick(sec_tick), .calendar_value(calendar_value),
		.tuner_power(tuner_power), .tuner_add(tuner_add), .tuner_adjust(tuner_adjust),
		.interval0_tap(interval0_tap), .interval1_tap(interval1_tap)
	);

	// Shares the bus, so both builds see identical traffic
	calendar_regs #(
		.TUNER_PRESENT(1'b0), .TUNER_POWER_WRITABLE(1'b0), .TUNER_FIXED_POWER(5'h07),
		.INTERVAL0_TAP_WRITABLE(1'b0), .INTERVAL1_TAP_WRITABLE(1'b1)
	) i_dut_alt (
		.sys_clk(sys_clk), .nrst(nrst), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data_alt), .busy(busy),
		.sec_tick(sec_tick), .calendar_value(), .tuner_power(tuner_power_alt),
		.tuner_add(), .tuner_adjust(), .interval0_tap(interval0_tap_alt),
		.interval1_tap(interval1_tap_alt)
	);

	// Clock at 40 MHz
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check

	// Strobe rises after one edge and drops after the next: no double drive
	task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge sys_clk);
		wr_en <= 1'b0;
	endtask : bus_write

	// Read data stands only in the cycle after the strobe
	task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		#1;
		d = rd_data;
	endtask : bus_read

	function automatic logic [31:0] pack_cal(input logic [5:0] y, input logic [3:0] mo,
		input logic [4:0] d, input logic [4:0] h, input logic [5:0] mi, input logic [5:0] s);
		pack_cal = (32'(y) << cal_pkg::YEAR_LSB) | (32'(mo) << cal_pkg::MONTH_LSB) |
			(32'(d) << cal_pkg::DAY_LSB) | (32'(h) << cal_pkg::HOUR_LSB) |
			(32'(mi) << cal_pkg::MIN_LSB) | (32'(s) << cal_pkg::SEC_LSB);
	endfunction : pack_cal

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Build options, read-only and unmapped places
	task automatic test_options();
		logic [31:0] v;
		logic [31:0] alt_exp;
		alt_exp = (32'h0000_0007 << cal_pkg::OPT_POWER_LSB) |
			(32'h0000_0001 << cal_pkg::OPT_ALARM_LSB) |
			(32'h0000_0001 << cal_pkg::OPT_TAP1_WA_BIT);
		bus_write(cal_pkg::OFF_OPTS, 32'hFFFF_FFFF);
		bus_read(cal_pkg::OFF_OPTS, v);
		check(v, 32'h0000_4103);
		check(rd_data_alt, alt_exp);
		bus_read(8'h00, v);
		check(v, 32'h0000_0000);
		$display("options test done");
	endtask : test_options

	// Field packing and read back
	task automatic test_pack();
		logic [31:0] v;
		logic [31:0] e;
		e = pack_cal(6'h2A, 4'hC, 5'h1F, 5'h17, 6'h3B, 6'h3B);
		bus_write(cal_pkg::OFF_CAL, e);
		bus_read(cal_pkg::OFF_CAL, v);
		check(v, e);
		check(calendar_value, e);
		$display("pack test done");
	endtask : test_pack

	// Busy drops writes and hides the value
	task automatic test_busy();
		logic [31:0] v;
		logic [31:0] a;
		a = pack_cal(6'h05, 4'h3, 5'h0A, 5'h08, 6'h1E, 6'h02);
		bus_write(cal_pkg::OFF_CAL, a);
		@(posedge sys_clk);
		busy <= 1'b1;
		bus_write(cal_pkg::OFF_CAL, 32'h1234_5678);
		bus_read(cal_pkg::OFF_CAL, v);
		check(v, 32'h0000_0000);
		check(calendar_value, a);
		@(posedge sys_clk);
		busy <= 1'b0;
		bus_read(cal_pkg::OFF_CAL, v);
		check(v, a);
		$display("busy test done");
	endtask : test_busy

	// One tick from a written start value
	task automatic tick_case(input logic [31:0] start, input logic [31:0] exp);
		bus_write(cal_pkg::OFF_CAL, start);
		@(posedge sys_clk);
		sec_tick <= 1'b1;
		@(posedge sys_clk);
		sec_tick <= 1'b0;
		#1;
		check(calendar_value, exp);
	endtask : tick_case

	// Carries at every field edge, leap years included
	task automatic test_ticks();
		tick_case(pack_cal(6'h03, 4'h6, 5'h0A, 5'h0A, 6'h14, 6'h1E),
			pack_cal(6'h03, 4'h6, 5'h0A, 5'h0A, 6'h14, 6'h1F));
		tick_case(pack_cal(6'h03, 4'h6, 5'h0A, 5'h0C, 6'h3B, 6'h3B),
			pack_cal(6'h03, 4'h6, 5'h0A, 5'h0D, 6'h00, 6'h00));
		tick_case(pack_cal(6'h03, 4'hC, 5'h1F, 5'h17, 6'h3B, 6'h3B),
			pack_cal(6'h04, 4'h1, 5'h01, 5'h00, 6'h00, 6'h00));
		tick_case(pack_cal(6'h04, 4'h2, 5'h1C, 5'h17, 6'h3B, 6'h3B),
			pack_cal(6'h04, 4'h2, 5'h1D, 5'h00, 6'h00, 6'h00));
		tick_case(pack_cal(6'h04, 4'h2, 5'h1D, 5'h17, 6'h3B, 6'h3B),
			pack_cal(6'h04, 4'h3, 5'h01, 5'h00, 6'h00, 6'h00));
		tick_case(pack_cal(6'h05, 4'h2, 5'h1C, 5'h17, 6'h3B, 6'h3B),
			pack_cal(6'h05, 4'h3, 5'h01, 5'h00, 6'h00, 6'h00));
		$display("tick test done");
	endtask : test_ticks

	// Writable and fixed tuner power and taps
	task automatic test_fixed_fields();
		logic [31:0] v;
		bus_write(cal_pkg::OFF_TUNER, 32'h0000_5A2A);
		bus_write(cal_pkg::OFF_TAP0, 32'h0000_0011);
		bus_write(cal_pkg::OFF_TAP0 + cal_pkg::OFF_TAP_STEP, 32'h0000_0009);
		bus_read(cal_pkg::OFF_TUNER, v);
		check(v, 32'h0000_5A2A);
		check(rd_data_alt, 32'h0000_0000);
		check({27'h0, tuner_power}, 32'h0000_000A);
		check({23'h0, tuner_add, tuner_adjust}, 32'h0000_015A);
		check({27'h0, tuner_power_alt}, 32'h0000_0007);
		check({27'h0, interval0_tap}, 32'h0000_0011);
		check({27'h0, interval1_tap}, 32'h0000_0000);
		check({27'h0, interval0_tap_alt}, 32'h0000_0000);
		check({27'h0, interval1_tap_alt}, 32'h0000_0009);
		$display("fixed field test done");
	endtask : test_fixed_fields

	// ------------------------------------------------------------
	// Verdict and sequence
	// ------------------------------------------------------------
	task automatic complete_run();
		$display("checks=%0d mismatches=%0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run

	// Whole run is under a hundred cycles; this leaves ample margin
	initial begin
		repeat (5000) @(posedge sys_clk);
		errors++;
		complete_run();
	end

	initial begin
		errors = 0;
		total_checks = 0;
		nrst = 1'b0;
		addr = 8'h00;
		wr_data = 32'h0000_0000;
		wr_en = 1'b0;
		rd_en = 1'b0;
		busy = 1'b0;
		sec_tick = 1'b0;
		repeat (12) @(posedge sys_clk);
		nrst <= 1'b1;
		#1;
		check(calendar_value, 32'h0000_0000);
		test_options();
		test_pack();
		test_busy();
		test_ticks();
		test_fixed_fields();
		complete_run();
	end

endmodule : calendar_regs_tb_top
